// ===== jbs_defines.svh
`ifndef JBS_DEFINES_SVH
`define JBS_DEFINES_SVH

// Instruction register width and documented opcodes
`define JBS_IR_W 8
`define JBS_OP_EXTEST 8'h00
`define JBS_OP_SAMPLE 8'h01
`define JBS_OP_IDCODE 8'h03
`define JBS_OP_HIGHZ 8'h10
`define JBS_OP_BYPASS 8'hff
// Debug support opcodes in the 0x80 to 0xFE block
`define JBS_OP_DBG_ADDR 8'h88
`define JBS_OP_DBG_DATA 8'h89
`define JBS_OP_DBG_CTRL 8'h8a
`define JBS_OP_DBG_MOUNT 8'h8b
// Capture pattern and reset instruction
`define JBS_IR_CAPTURE 8'h03
`define JBS_IR_RESET `JBS_OP_IDCODE

// Data register lengths
`define JBS_BSR_LEN 391
`define JBS_WORD_LEN 32
`define JBS_LEN_W 9

// Identification values (arbitrary, bit 0 must stay one)
`define JBS_IDCODE_VAL 32'h0000_1001
`define JBS_MOUNT_VAL 32'h0000_0001

`endif

// ===== jbs_pkg.sv
package jbs_pkg;

  // Test access port controller states
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PA_DR,
    TAP_EX2_DR, TAP_UP_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PA_IR,
    TAP_EX2_IR, TAP_UP_IR
  } jbs_tap_t;

  // Data register connected between the serial pins
  typedef enum logic [2:0] {
    DR_BYPASS, DR_BSR, DR_ID, DR_ADDR, DR_DATA, DR_CTRL, DR_MOUNT
  } jbs_dr_t;

endpackage

// ===== jbs_tap.sv
`timescale 1ns/10ps
`include "jbs_defines.svh"
// Function
// - Standard test access port controller runs from the test clock, mode, data and reset pins.
// - Instruction register is an 8-bit shifter between serial in and out on the IR path.
// - Latched instruction picks the test action and the one connected data register.
// - Codes 0x00 and 0x01 use the boundary chain; code 0x03 connects the ID register.
// - Five scan instructions; 0x10 high-impedance and 0xFF bypass use the one-bit bypass.
// - Instruction codes shift in least significant bit first.
// - One 391-bit boundary chain, one cell per scanned signal.
// - Supply, the five test pins and the test-mode pin have no chain cell.
// - Serial input enters bit 390; cells move one place toward bit zero per shift.
// - Serial output shows bit zero of the boundary chain while it shifts.
// - Data registers: boundary, bypass, ID, debug address, data, control and mount.
// - With trace mode on, boundary scan and the debug address, data and control registers are bypassed; ID and mount stay.
// - In execution control mode the probe runs, breaks, steps and reaches registers and memory.
module jbs_tap #(
  parameter int BSR_LEN = `JBS_BSR_LEN
) (
  // System clock domain
  input wire logic clk,
  input wire logic sys_rst,
  // Test link, clocked by tck
  input wire logic tck,
  input wire logic trst_n,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  // Scanned pin values and pin control
  input wire logic [BSR_LEN-1:0] pin_in,
  output logic [BSR_LEN-1:0] pin_out,
  output logic pin_test_drive,
  output logic pin_highz,
  // Debug support unit side
  input wire logic trace_select_mode,
  input wire logic [31:0] dsu_rdata,
  input wire logic [31:0] dsu_status,
  output logic [31:0] dsu_addr,
  output logic [31:0] dsu_wdata,
  output logic [31:0] dsu_ctrl,
  output logic dsu_ctrl_strobe
);

  jbs_pkg::jbs_tap_t state;
  jbs_pkg::jbs_tap_t next_state;
  jbs_pkg::jbs_dr_t dr_sel;
  logic [`JBS_IR_W-1:0] ir_sh;
  logic [`JBS_IR_W-1:0] ir;
  logic [BSR_LEN-1:0] dr_sh;
  logic [BSR_LEN-1:0] dr_cap;
  logic [`JBS_LEN_W-1:0] dr_len;
  logic [BSR_LEN-1:0] pin_s1, pin_s2;
  logic [31:0] rdata_s1, rdata_s2;
  logic [31:0] status_s1, status_s2;
  logic trace_s1, trace_s2;
  logic [BSR_LEN-1:0] hold_bsr;
  logic [31:0] hold_addr, hold_data, hold_ctrl;
  logic hold_ctrl_hit, upd_tog;
  logic tog_s1, tog_s2, tog_s3;
  logic drive_t, highz_t;
  logic drive_s1, drive_s2;
  logic highz_s1, highz_s2;

  // Controller next state from the mode-select pin
  always_comb
  begin
    next_state = jbs_pkg::TAP_RESET;
    case (state)
      jbs_pkg::TAP_RESET:  next_state = tms ? jbs_pkg::TAP_RESET : jbs_pkg::TAP_IDLE;
      jbs_pkg::TAP_IDLE:   next_state = tms ? jbs_pkg::TAP_SEL_DR : jbs_pkg::TAP_IDLE;
      jbs_pkg::TAP_SEL_DR: next_state = tms ? jbs_pkg::TAP_SEL_IR : jbs_pkg::TAP_CAP_DR;
      jbs_pkg::TAP_CAP_DR: next_state = tms ? jbs_pkg::TAP_EX1_DR : jbs_pkg::TAP_SH_DR;
      jbs_pkg::TAP_SH_DR:  next_state = tms ? jbs_pkg::TAP_EX1_DR : jbs_pkg::TAP_SH_DR;
      jbs_pkg::TAP_EX1_DR: next_state = tms ? jbs_pkg::TAP_UP_DR : jbs_pkg::TAP_PA_DR;
      jbs_pkg::TAP_PA_DR:  next_state = tms ? jbs_pkg::TAP_EX2_DR : jbs_pkg::TAP_PA_DR;
      jbs_pkg::TAP_EX2_DR: next_state = tms ? jbs_pkg::TAP_UP_DR : jbs_pkg::TAP_SH_DR;
      jbs_pkg::TAP_UP_DR:  next_state = tms ? jbs_pkg::TAP_SEL_DR : jbs_pkg::TAP_IDLE;
      jbs_pkg::TAP_SEL_IR: next_state = tms ? jbs_pkg::TAP_RESET : jbs_pkg::TAP_CAP_IR;
      jbs_pkg::TAP_CAP_IR: next_state = tms ? jbs_pkg::TAP_EX1_IR : jbs_pkg::TAP_SH_IR;
      jbs_pkg::TAP_SH_IR:  next_state = tms ? jbs_pkg::TAP_EX1_IR : jbs_pkg::TAP_SH_IR;
      jbs_pkg::TAP_EX1_IR: next_state = tms ? jbs_pkg::TAP_UP_IR : jbs_pkg::TAP_PA_IR;
      jbs_pkg::TAP_PA_IR:  next_state = tms ? jbs_pkg::TAP_EX2_IR : jbs_pkg::TAP_PA_IR;
      jbs_pkg::TAP_EX2_IR: next_state = tms ? jbs_pkg::TAP_UP_IR : jbs_pkg::TAP_SH_IR;
      jbs_pkg::TAP_UP_IR:  next_state = tms ? jbs_pkg::TAP_SEL_DR : jbs_pkg::TAP_IDLE;
      default:             next_state = jbs_pkg::TAP_RESET;
    endcase
  end

  // Controller state, forced to reset by the test reset pin
  always_ff @(posedge tck or negedge trst_n)
  begin
    if (!trst_n)
      state <= jbs_pkg::TAP_RESET;
    else
      state <= next_state;
  end

  // Instruction shifter: capture pattern, then shift toward bit zero
  always_ff @(posedge tck or negedge trst_n)
  begin
    if (!trst_n)
      ir_sh <= `JBS_IR_CAPTURE;
    else if (state == jbs_pkg::TAP_CAP_IR)
      ir_sh <= `JBS_IR_CAPTURE;
    else if (state == jbs_pkg::TAP_SH_IR)
      ir_sh <= {tdi, ir_sh[`JBS_IR_W-1:1]};
  end

  // Latched instruction, loaded on update or set to the ID instruction on reset
  always_ff @(posedge tck or negedge trst_n)
  begin
    if (!trst_n)
      ir <= `JBS_IR_RESET;
    else if (state == jbs_pkg::TAP_RESET)
      ir <= `JBS_IR_RESET;
    else if (state == jbs_pkg::TAP_UP_IR)
      ir <= ir_sh;
  end

  // Decode of the latched instruction into the connected register
  always_comb
  begin
    dr_sel = jbs_pkg::DR_BYPASS;
    drive_t = 1'b0;
    highz_t = 1'b0;
    case (ir)
      `JBS_OP_EXTEST:
      begin
        dr_sel = trace_s2 ? jbs_pkg::DR_BYPASS : jbs_pkg::DR_BSR;
        drive_t = !trace_s2;
      end
      `JBS_OP_SAMPLE: dr_sel = trace_s2 ? jbs_pkg::DR_BYPASS : jbs_pkg::DR_BSR;
      `JBS_OP_IDCODE: dr_sel = jbs_pkg::DR_ID;
      `JBS_OP_HIGHZ:
      begin
        dr_sel = jbs_pkg::DR_BYPASS;
        highz_t = !trace_s2;
      end
      `JBS_OP_DBG_ADDR: dr_sel = trace_s2 ? jbs_pkg::DR_BYPASS : jbs_pkg::DR_ADDR;
      `JBS_OP_DBG_DATA: dr_sel = trace_s2 ? jbs_pkg::DR_BYPASS : jbs_pkg::DR_DATA;
      `JBS_OP_DBG_CTRL: dr_sel = trace_s2 ? jbs_pkg::DR_BYPASS : jbs_pkg::DR_CTRL;
      `JBS_OP_DBG_MOUNT: dr_sel = jbs_pkg::DR_MOUNT;
      default: dr_sel = jbs_pkg::DR_BYPASS;
    endcase
  end

  // Length and capture value of the connected register
  always_comb
  begin
    dr_cap = '0;
    if (dr_sel == jbs_pkg::DR_BSR)
      dr_len = `JBS_LEN_W'(BSR_LEN);
    else if (dr_sel == jbs_pkg::DR_BYPASS)
      dr_len = `JBS_LEN_W'(1);
    else
      dr_len = `JBS_LEN_W'(`JBS_WORD_LEN);
    case (dr_sel)
      jbs_pkg::DR_BSR: dr_cap = pin_s2;
      jbs_pkg::DR_ID: dr_cap[31:0] = `JBS_IDCODE_VAL;
      jbs_pkg::DR_ADDR: dr_cap[31:0] = hold_addr;
      jbs_pkg::DR_DATA: dr_cap[31:0] = rdata_s2;
      jbs_pkg::DR_CTRL: dr_cap[31:0] = status_s2;
      jbs_pkg::DR_MOUNT: dr_cap[31:0] = `JBS_MOUNT_VAL;
      default: dr_cap = '0;
    endcase
  end

  // Shared data shifter: serial input enters the top cell of the selected length
  for (genvar i = 0; i < BSR_LEN; i++)
  begin : g_cell
    always_ff @(posedge tck or negedge trst_n)
    begin
      if (!trst_n)
        dr_sh[i] <= 1'b0;
      else if (state == jbs_pkg::TAP_CAP_DR)
        dr_sh[i] <= dr_cap[i];
      else if (state == jbs_pkg::TAP_SH_DR)
      begin
        if (`JBS_LEN_W'(i + 1) == dr_len)
          dr_sh[i] <= tdi;
        else if (`JBS_LEN_W'(i + 1) < dr_len && i + 1 < BSR_LEN)
          dr_sh[i] <= dr_sh[(i + 1) % BSR_LEN];
        else
          dr_sh[i] <= 1'b0;
      end
    end
  end

  // Serial output changes on the falling test clock edge
  always_ff @(negedge tck or negedge trst_n)
  begin
    if (!trst_n)
    begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end
    else
    begin
      tdo <= (state == jbs_pkg::TAP_SH_IR) ? ir_sh[0] : dr_sh[0];
      tdo_oe <= (state == jbs_pkg::TAP_SH_IR) || (state == jbs_pkg::TAP_SH_DR);
    end
  end

  // Level inputs into the test clock domain
  always_ff @(posedge tck or negedge trst_n)
  begin
    if (!trst_n)
    begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      rdata_s1 <= '0;
      rdata_s2 <= '0;
      status_s1 <= '0;
      status_s2 <= '0;
      trace_s1 <= 1'b0;
      trace_s2 <= 1'b0;
    end
    else
    begin
      pin_s1 <= pin_in;
      pin_s2 <= pin_s1;
      rdata_s1 <= dsu_rdata;
      rdata_s2 <= rdata_s1;
      status_s1 <= dsu_status;
      status_s2 <= status_s1;
      trace_s1 <= trace_select_mode;
      trace_s2 <= trace_s1;
    end
  end

  // Update words held stable for the system domain, announced by a toggle
  always_ff @(posedge tck or negedge trst_n)
  begin
    if (!trst_n)
    begin
      hold_bsr <= '0;
      hold_addr <= '0;
      hold_data <= '0;
      hold_ctrl <= '0;
      hold_ctrl_hit <= 1'b0;
      upd_tog <= 1'b0;
    end
    else if (state == jbs_pkg::TAP_UP_DR && dr_sel != jbs_pkg::DR_BYPASS
             && dr_sel != jbs_pkg::DR_ID && dr_sel != jbs_pkg::DR_MOUNT)
    begin
      if (dr_sel == jbs_pkg::DR_BSR)
        hold_bsr <= dr_sh;
      if (dr_sel == jbs_pkg::DR_ADDR)
        hold_addr <= dr_sh[31:0];
      if (dr_sel == jbs_pkg::DR_DATA)
        hold_data <= dr_sh[31:0];
      if (dr_sel == jbs_pkg::DR_CTRL)
        hold_ctrl <= dr_sh[31:0];
      hold_ctrl_hit <= (dr_sel == jbs_pkg::DR_CTRL);
      upd_tog <= !upd_tog;
    end
  end

  // Toggle sync keeps running in system reset, so no false update edge follows it
  always_ff @(posedge clk)
  begin
    tog_s1 <= upd_tog;
    tog_s2 <= tog_s1;
    tog_s3 <= tog_s2;
  end

  // Mode levels into the system clock domain
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      drive_s1 <= 1'b0;
      drive_s2 <= 1'b0;
      highz_s1 <= 1'b0;
      highz_s2 <= 1'b0;
    end
    else
    begin
      drive_s1 <= drive_t;
      drive_s2 <= drive_s1;
      highz_s1 <= highz_t;
      highz_s2 <= highz_s1;
    end
  end

  // System side copies of the update words
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pin_out <= '0;
      dsu_addr <= '0;
      dsu_wdata <= '0;
      dsu_ctrl <= '0;
      dsu_ctrl_strobe <= 1'b0;
      pin_test_drive <= 1'b0;
      pin_highz <= 1'b0;
    end
    else
    begin
      dsu_ctrl_strobe <= (tog_s2 != tog_s3) && hold_ctrl_hit;
      pin_test_drive <= drive_s2;
      pin_highz <= highz_s2;
      if (tog_s2 != tog_s3)
      begin
        pin_out <= hold_bsr;
        dsu_addr <= hold_addr;
        dsu_wdata <= hold_data;
        dsu_ctrl <= hold_ctrl;
      end
    end
  end

  // Checks in the test clock domain
  sequence s_tms_high;
    tms [*5];
  endsequence

  sequence s_shift_bsr;
    state == jbs_pkg::TAP_SH_DR && dr_sel == jbs_pkg::DR_BSR;
  endsequence

  chk_tms_reset: assert property (@(posedge tck) disable iff (!trst_n)
    s_tms_high |=> state == jbs_pkg::TAP_RESET)
    else $error("five high mode cycles did not reach reset");
  chk_ir_capture: assert property (@(posedge tck) disable iff (!trst_n)
    state == jbs_pkg::TAP_CAP_IR |=> ir_sh == `JBS_IR_CAPTURE)
    else $error("capture-IR pattern wrong");
  chk_ir_lsb_first: assert property (@(posedge tck) disable iff (!trst_n)
    state == jbs_pkg::TAP_SH_IR |=> ir_sh == {$past(tdi), $past(ir_sh[7:1])})
    else $error("instruction shift order wrong");
  chk_ir_update: assert property (@(posedge tck) disable iff (!trst_n)
    state == jbs_pkg::TAP_UP_IR |=> ir == $past(ir_sh))
    else $error("instruction not latched on update");
  chk_reset_idcode: assert property (@(posedge tck) disable iff (!trst_n)
    state == jbs_pkg::TAP_RESET |=> ir == `JBS_OP_IDCODE)
    else $error("reset did not load ID instruction");
  chk_bsr_msb_in: assert property (@(posedge tck) disable iff (!trst_n)
    s_shift_bsr |=> dr_sh[BSR_LEN-1] == $past(tdi) && dr_sh[0] == $past(dr_sh[1]))
    else $error("boundary chain shift wrong");
  chk_bypass_path: assert property (@(posedge tck) disable iff (!trst_n)
    state == jbs_pkg::TAP_SH_DR && dr_sel == jbs_pkg::DR_BYPASS |=> dr_sh[0] == $past(tdi))
    else $error("bypass stage wrong");
  chk_decode_map: assert property (@(posedge tck) disable iff (!trst_n)
    (ir == `JBS_OP_IDCODE |-> dr_sel == jbs_pkg::DR_ID)
    and (ir == `JBS_OP_HIGHZ |-> dr_sel == jbs_pkg::DR_BYPASS))
    else $error("instruction decode wrong");
  chk_trace_no_bsr: assert property (@(posedge tck) disable iff (!trst_n)
    trace_s2 |-> dr_sel != jbs_pkg::DR_BSR && !drive_t)
    else $error("boundary scan active in trace mode");
  chk_tdo_bit0: assert property (@(posedge tck) disable iff (!trst_n)
    s_shift_bsr ##1 state == jbs_pkg::TAP_SH_DR |-> tdo == dr_sh[0])
    else $error("serial output not from bit zero");

  // Check in the system clock domain
  chk_pin_update: assert property (@(posedge clk) disable iff (sys_rst)
    tog_s2 != tog_s3 |=> pin_out == $past(hold_bsr))
    else $error("boundary update not copied");

endmodule

// ===== jbs_probe.sv
`timescale 1ns/10ps
module jbs_probe (
  // Test link driven toward the device
  output logic tck,
  output logic trst_n,
  output logic tms,
  output logic tdi,
  // Serial answer from the device
  input wire logic tdo
);
  // Clock stands still low between frames, port held in reset at start
  initial
  begin
    tck = 1'b0;
    trst_n = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // One link clock: drive while low, take tdo at the rising edge
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #15;
    tck = 1'b1;
    o = tdo;
    #15;
    tck = 1'b0;
  endtask

  // Asynchronous test reset pulse, released between frames
  task automatic pulse_reset();
    trst_n = 1'b0;
    #7;
    trst_n = 1'b1;
    #8;
  endtask

  // Five high mode bits reach reset from any state, then settle in idle
  task automatic mode_reset();
    logic o;
    for (int i = 0; i < 5; i++)
      step(1'b1, ~tdi, o);
    step(1'b0, ~tdi, o);
  endtask

  // Shift len bits through the IR or DR path from idle, back to idle
  task automatic scan(input logic ir, input int len, input logic [399:0] din,
                      output logic [399:0] dout);
    logic o;
    dout = '0;
    step(1'b1, ~tdi, o);
    if (ir)
      step(1'b1, ~tdi, o);
    step(1'b0, ~tdi, o);
    step(1'b0, ~tdi, o);
    // Bit zero goes first; tdi is released to the inverse afterwards
    for (int i = 0; i < len; i++)
      step(i == len - 1, din[i], dout[i]);
    step(1'b1, ~tdi, o);
    step(1'b0, ~tdi, o);
  endtask
endmodule

// ===== jtag_boundary_scan_tap_test.sv
`timescale 1ns/10ps
`include "jbs_defines.svh"
module jtag_boundary_scan_tap_test;
  typedef struct {
    logic [7:0] op;
    logic tr;
    int len;
    logic [399:0] cap;
    int kind;
    logic drive;
    logic hz;
  } jbs_row_t;
  localparam logic [399:0] PAT = {25{16'hC3A5}};
  localparam logic [399:0] PIN_CAP = {9'h000, {12{32'h3C5A_96E1}}, 7'h61};
  localparam logic [31:0] RDATA = 32'h1234_5678;
  localparam logic [31:0] STATUS = 32'h0BAD_F00D;
  logic clk, sys_rst, tck, trst_n, tms, tdi, tdo, tdo_oe, trace_select_mode;
  logic pin_test_drive, pin_highz, dsu_ctrl_strobe;
  logic [390:0] pin_in, pin_out;
  logic [31:0] dsu_rdata, dsu_status, dsu_addr, dsu_wdata, dsu_ctrl;
  logic [399:0] got;
  int bad_count = 0;
  int check_count = 0;
  int strobe_count = 0;
  int cycles = 0;
  jbs_row_t rows[14];

  jbs_tap i_jbs_tap (.clk(clk), .sys_rst(sys_rst), .tck(tck), .trst_n(trst_n), .tms(tms),
    .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .pin_in(pin_in), .pin_out(pin_out),
    .pin_test_drive(pin_test_drive), .pin_highz(pin_highz),
    .trace_select_mode(trace_select_mode), .dsu_rdata(dsu_rdata), .dsu_status(dsu_status),
    .dsu_addr(dsu_addr), .dsu_wdata(dsu_wdata), .dsu_ctrl(dsu_ctrl),
    .dsu_ctrl_strobe(dsu_ctrl_strobe));
  jbs_probe i_jbs_probe (.tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi), .tdo(tdo));

  // System clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Strobe pulses and the hang limit
  always @(posedge clk)
  begin
    cycles++;
    if (dsu_ctrl_strobe === 1'b1)
      strobe_count++;
    if (cycles == 40000)
    begin
      bad_count++;
      final_report();
    end
  end

  task automatic cmp_vec(input string name, input logic [399:0] e, input logic [399:0] g);
    check_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic cmp_bit(input string name, input logic e, input logic g);
    check_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value %s expected %b seen %b", name, e, g);
    end
  endtask

  // Load an instruction, then shift a data register len plus eight bits
  task automatic run_pair(input logic [7:0] op, input int len, input logic [399:0] cap);
    i_jbs_probe.scan(1'b1, 8, {392'h0, op}, got);
    cmp_vec("ir capture", 400'h3, got & 400'hff);
    i_jbs_probe.scan(1'b0, len + 8, PAT, got);
    cmp_vec("dr capture", cap, got & ~({400{1'b1}} << len));
    cmp_vec("dr length", PAT & 400'hff, (got >> len) & 400'hff);
  endtask

  task automatic final_report();
    if (bad_count == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Main sequence: table of instructions, then the reset cases
  initial
  begin
    rows[0] = '{8'h00, 1'b0, 391, PIN_CAP, 1, 1'b1, 1'b0};
    rows[1] = '{8'h01, 1'b0, 391, PIN_CAP, 1, 1'b0, 1'b0};
    rows[2] = '{8'h03, 1'b0, 32, `JBS_IDCODE_VAL, 0, 1'b0, 1'b0};
    rows[3] = '{8'h10, 1'b0, 1, 400'h0, 0, 1'b0, 1'b1};
    rows[4] = '{8'hff, 1'b0, 1, 400'h0, 0, 1'b0, 1'b0};
    rows[5] = '{8'h02, 1'b0, 1, 400'h0, 0, 1'b0, 1'b0};
    rows[6] = '{8'h20, 1'b0, 1, 400'h0, 0, 1'b0, 1'b0};
    rows[7] = '{8'h88, 1'b0, 32, 400'h0, 2, 1'b0, 1'b0};
    rows[8] = '{8'h88, 1'b0, 32, PAT[39:8], 2, 1'b0, 1'b0};
    rows[9] = '{8'h89, 1'b0, 32, RDATA, 3, 1'b0, 1'b0};
    rows[10] = '{8'h8a, 1'b0, 32, STATUS, 4, 1'b0, 1'b0};
    rows[11] = '{8'h8b, 1'b0, 32, `JBS_MOUNT_VAL, 0, 1'b0, 1'b0};
    rows[12] = '{8'h00, 1'b1, 1, 400'h0, 0, 1'b0, 1'b0};
    rows[13] = '{8'h8b, 1'b1, 32, `JBS_MOUNT_VAL, 0, 1'b0, 1'b0};
    sys_rst <= 1'b1;
    trace_select_mode <= 1'b0;
    pin_in <= PIN_CAP[390:0];
    dsu_rdata <= RDATA;
    dsu_status <= STATUS;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    i_jbs_probe.pulse_reset();
    i_jbs_probe.mode_reset();
    for (int r = 0; r < 14; r++)
    begin
      @(posedge clk);
      trace_select_mode <= rows[r].tr;
      @(posedge clk);
      run_pair(rows[r].op, rows[r].len, rows[r].cap);
      repeat (6) @(posedge clk);
      cmp_bit("test drive", rows[r].drive, pin_test_drive);
      cmp_bit("high impedance", rows[r].hz, pin_highz);
      case (rows[r].kind)
        1: cmp_vec("pin out", PAT[398:8], pin_out);
        2: cmp_vec("debug address", PAT[39:8], dsu_addr);
        3: cmp_vec("debug data", PAT[39:8], dsu_wdata);
        4:
        begin
          cmp_vec("debug control", PAT[39:8], dsu_ctrl);
          cmp_vec("control strobes", 400'h1, strobe_count);
        end
        default: ;
      endcase
    end
    // Five high mode bits bring back the identification instruction
    @(posedge clk);
    trace_select_mode <= 1'b0;
    run_pair(8'hff, 1, 400'h0);
    i_jbs_probe.mode_reset();
    i_jbs_probe.scan(1'b0, 40, PAT, got);
    cmp_vec("id after mode reset", `JBS_IDCODE_VAL, got & 400'hffff_ffff);
    // Test reset pin does the same, leaving the serial output released
    run_pair(8'h10, 1, 400'h0);
    i_jbs_probe.pulse_reset();
    i_jbs_probe.mode_reset();
    cmp_bit("tdo enable", 1'b0, tdo_oe);
    cmp_bit("high impedance", 1'b0, pin_highz);
    i_jbs_probe.scan(1'b0, 40, PAT, got);
    cmp_vec("id after test reset", `JBS_IDCODE_VAL, got & 400'hffff_ffff);
    // System reset clears the pin and debug outputs
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    cmp_vec("pin out reset", 400'h0, pin_out);
    cmp_vec("debug address reset", 400'h0, dsu_addr);
    final_report();
  end
endmodule
